// >>> shared/iapg_cfg.svh
`ifndef IAPG_CFG_SVH
`define IAPG_CFG_SVH
// ==================================================================
// Main register space addresses
`define IAPG_A_IND_CTL    8'hb0
`define IAPG_A_IND_OFF    8'hb1
`define IAPG_A_IND_DATA   8'hb2
`define IAPG_A_P1_ALIAS   8'hf9
`define IAPG_A_RSVD_FA    8'hfa
`define IAPG_A_RSVD_FB    8'hfb
// ==================================================================
// Indirect control fields
`define IAPG_CTL_AINC     1
`define IAPG_CTL_PG_LO    2
`define IAPG_CTL_PG_HI    5
`define IAPG_CTL_MASK     8'h3e
// ==================================================================
// Indirect page codes
`define IAPG_PG_TP        4'h0
`define IAPG_PG_CH0       4'h1
`define IAPG_PG_CH1       4'h2
`define IAPG_PG_SHARE     4'h5
`define IAPG_PG_ALL       4'h6
`define IAPG_PG_CSI       4'h7
// ==================================================================
// Page 0 offsets and windows, last offsets of the other pages
`define IAPG_O_RSVD0      8'h00
`define IAPG_O_TP_CTL     8'h01
`define IAPG_O_TP_CFG     8'h02
`define IAPG_O_TP_PID     8'h03
`define IAPG_O_LEN_HI     8'h04
`define IAPG_O_LEN_LO     8'h05
`define IAPG_O_TP_END     8'h1f
`define IAPG_O_TIM_LO     8'h40
`define IAPG_O_TIM_HI     8'h48
`define IAPG_O_CH_END     8'h14
`define IAPG_O_SHR_END    8'h04
`define IAPG_O_CSI_END    8'h1d
`define IAPG_TIM_BASE     9'h100
// ==================================================================
// Reset values
`define IAPG_RST_ZERO     8'h00
`define IAPG_RST_CFG      8'h33
`define IAPG_RST_PID      8'h24
`define IAPG_RST_LEN_HI   8'h07
`define IAPG_RST_LEN_LO   8'h80
// ==================================================================
// Field positions and offset step
`define IAPG_TP_ON        0
`define IAPG_FIX_BIT      7
`define IAPG_BARS_HI      5
`define IAPG_BARS_LO      4
`define IAPG_BLK_HI       3
`define IAPG_VC_HI        7
`define IAPG_VC_LO        6
`define IAPG_DT_HI        5
`define IAPG_ALIAS_LO     1
`define IAPG_OFF_STEP     8'h01
`endif

// >>> shared/iapg_pkg.sv
package iapg_pkg;
    // Access sequencer states
    typedef enum logic [1:0] {
        IAPG_IDLE,
        IAPG_READ,
        IAPG_WALL
    } iapg_state_e;
    // Whole state of the register bank
    typedef struct packed {
        iapg_state_e st;
        logic [7:0]  ctl;
        logic [7:0]  off;
        logic [6:0]  alias_id;
        logic [7:0]  tp_ctl;
        logic [7:0]  tp_cfg;
        logic [7:0]  tp_pid;
        logic [7:0]  len_hi;
        logic [7:0]  len_lo;
        logic [7:0]  rhold;
        logic        from_mem;
        logic [7:0]  rdata;
        logic        ack;
        logic [7:0]  whold;
        logic [7:0]  woff;
        logic        p1_match;
    } iapg_state_s;
    // Memory index width
    typedef logic [8:0] iapg_idx_t;
endpackage

// >>> design/iapg_mem.sv
`timescale 1ns/1ns
// ==================================================================
// Byte memory with registered read data
module iapg_mem #(
    parameter int DEPTH = 288,
    parameter int AW    = 9
) (
    // Clock
    input  wire logic          clk_sys,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    // Storage; no reset, contents undefined until written
    logic [7:0] mem [DEPTH];
    // ==============================================================
    // Write and registered read
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// >>> design/iapg_regbank.sv
// Summary of operation
// - control, offset, data at 0xB0-0xB2
// - data read returns selected indirect register
// - auto-increment advances offset after data writes
// - auto-increment advances offset after data reads
// - control bits 5:2 select page
// - page 0 maps generator and timing
// - page 6 writes both channels, channel 0 then channel 1
// - alias 7:1 address, zero disables, bit0 zero
// - control bit 0 enables generator, reset 0
// - config bit 7 picks fixed color
// - block size bits 3:0, reset 3
// - bits 7:6 give packet virtual channel
// - bits 5:0 give data type, 0x24
// - line length high byte 0x04, 0x07
// - line length low byte 0x05, 0x80
`timescale 1ns/1ns
`include "iapg_cfg.svh"
module iapg_regbank #(
    parameter int MEM_DEPTH = 288
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Byte register access from the control bus target
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_ack,
    output logic             reg_busy,
    // Target address decode for the second port
    input  wire logic [6:0]  i2c_target_addr,
    output logic             port1_match,
    // Pattern generator configuration
    output logic             testpattern_on,
    output logic             fixed_color_select,
    output logic [1:0]       color_bar_count,
    output logic [3:0]       bars_per_line,
    output logic [3:0]       block_size,
    output logic [1:0]       packet_virtual_channel,
    output logic [5:0]       packet_data_type,
    output logic [15:0]      active_line_bytes
);
    import iapg_pkg::*;

    // Registered state and its next value
    iapg_state_s s_reg;
    iapg_state_s s_next;

    // Memory port signals
    logic            mem_we;
    iapg_idx_t       mem_waddr;
    logic [7:0]      mem_wdata;
    iapg_idx_t       mem_raddr;
    logic [7:0]      mem_rdata;

    // Decode of the current indirect window
    logic [3:0]      page;
    logic [9:0]      map_cur;

    // ==============================================================
    // Helper functions
    // ==============================================================

    // Map a page and offset onto a memory slot; bit 9 marks a hit
    function automatic logic [9:0] map_ind(
        input logic [3:0] pg,
        input logic [7:0] o
    );
        logic       hit;
        iapg_idx_t  idx;
        hit = 1'b0;
        idx = '0;
        unique case (pg)
            `IAPG_PG_TP: begin
                // Upper generator registers and port 0 timing
                if (o > `IAPG_O_LEN_LO && o <= `IAPG_O_TP_END) begin
                    hit = 1'b1;
                    idx = {1'b0, o};
                end else if (o >= `IAPG_O_TIM_LO &&
                             o <= `IAPG_O_TIM_HI) begin
                    hit = 1'b1;
                    idx = `IAPG_TIM_BASE | {5'h00, o[3:0]};
                end
            end
            `IAPG_PG_SHARE: begin
                hit = (o <= `IAPG_O_SHR_END);
                idx = {1'b0, pg[2:0], o[4:0]};
            end
            `IAPG_PG_CSI: begin
                hit = (o <= `IAPG_O_CSI_END);
                idx = {1'b0, pg[2:0], o[4:0]};
            end
            `IAPG_PG_ALL: begin
                // Broadcast page reads back the channel 0 copy
                hit = (o <= `IAPG_O_CH_END);
                idx = {1'b0, 3'(`IAPG_PG_CH0), o[4:0]};
            end
            default: begin
                // Pages 1 to 4 hold per-channel test bytes
                if (pg[3] == 1'b0) begin
                    hit = (o <= `IAPG_O_CH_END);
                    idx = {1'b0, pg[2:0], o[4:0]};
                end
            end
        endcase
        return {hit, idx};
    endfunction

    // Decode the bar count code into a number of bars
    function automatic logic [3:0] bars_of(input logic [1:0] code);
        return 4'(4'h1 << code);
    endfunction

    // Offset after one data access, wrapping at the top
    function automatic logic [7:0] next_off(input logic [7:0] o);
        return 8'(o + `IAPG_OFF_STEP);
    endfunction

    // ==============================================================
    // Window decode
    // ==============================================================

    // Page field of the control register
    assign page = s_reg.ctl[`IAPG_CTL_PG_HI:`IAPG_CTL_PG_LO];
    assign map_cur = map_ind(page, s_reg.off);

    // ==============================================================
    // Indirect memory for the unmodelled register windows
    // ==============================================================
    iapg_mem #(
        .DEPTH (MEM_DEPTH),
        .AW    (9)
    ) u_mem (
        .clk_sys (clk_sys),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata   (mem_rdata)
    );

    // Read address always follows the live window so that the
    // registered read data is ready one cycle after a data read
    assign mem_raddr = map_cur[8:0];

    // ==============================================================
    // Next-state logic
    // ==============================================================
    always_comb begin
        s_next    = s_reg;
        s_next.ack = 1'b0;
        mem_we    = 1'b0;
        mem_waddr = map_cur[8:0];
        mem_wdata = reg_wdata;

        // Alias decoder; a zero alias never matches
        s_next.p1_match = (s_reg.alias_id != 7'h00) &&
                          (s_reg.alias_id == i2c_target_addr);

        unique case (s_reg.st)
            IAPG_IDLE: begin
                if (reg_wr) begin
                    // Write: answer on the next cycle; a broadcast data write to a mapped offset answers one cycle later
                    s_next.ack = 1'b1;
                    unique case (reg_addr)
                        `IAPG_A_IND_CTL: begin
                            // Only page and auto-increment stored
                            s_next.ctl = reg_wdata & `IAPG_CTL_MASK;
                        end
                        `IAPG_A_IND_OFF: begin
                            s_next.off = reg_wdata;
                        end
                        `IAPG_A_IND_DATA: begin
                            if (page == `IAPG_PG_TP) begin
                                // Modelled generator registers
                                unique case (s_reg.off)
                                    `IAPG_O_TP_CTL: begin
                                        s_next.tp_ctl = reg_wdata;
                                    end
                                    `IAPG_O_TP_CFG: begin
                                        s_next.tp_cfg = reg_wdata;
                                    end
                                    `IAPG_O_TP_PID: begin
                                        s_next.tp_pid = reg_wdata;
                                    end
                                    `IAPG_O_LEN_HI: begin
                                        s_next.len_hi = reg_wdata;
                                    end
                                    `IAPG_O_LEN_LO: begin
                                        s_next.len_lo = reg_wdata;
                                    end
                                    default: begin
                                        mem_we = map_cur[9];
                                    end
                                endcase
                            end else if (page == `IAPG_PG_ALL) begin
                                // Broadcast: channel 0 now, then 1
                                mem_we = map_cur[9];
                                if (map_cur[9]) begin
                                    s_next.ack   = 1'b0;
                                    s_next.st    = IAPG_WALL;
                                    s_next.whold = reg_wdata;
                                    s_next.woff  = s_reg.off;
                                end
                            end else begin
                                // Unmapped offsets drop the write
                                mem_we = map_cur[9];
                            end
                            if (s_reg.ctl[`IAPG_CTL_AINC]) begin
                                s_next.off = next_off(s_reg.off);
                            end
                        end
                        `IAPG_A_P1_ALIAS: begin
                            s_next.alias_id =
                                reg_wdata[7:`IAPG_ALIAS_LO];
                        end
                        default: begin
                            // Read-only and unmapped: no effect
                        end
                    endcase
                end else if (reg_rd) begin
                    // Read: capture now, answer two cycles later
                    s_next.st       = IAPG_READ;
                    s_next.from_mem = 1'b0;
                    s_next.rhold    = `IAPG_RST_ZERO;
                    unique case (reg_addr)
                        `IAPG_A_IND_CTL: begin
                            s_next.rhold = s_reg.ctl;
                        end
                        `IAPG_A_IND_OFF: begin
                            s_next.rhold = s_reg.off;
                        end
                        `IAPG_A_IND_DATA: begin
                            if (page == `IAPG_PG_TP) begin
                                unique case (s_reg.off)
                                    `IAPG_O_TP_CTL: begin
                                        s_next.rhold = s_reg.tp_ctl;
                                    end
                                    `IAPG_O_TP_CFG: begin
                                        s_next.rhold = s_reg.tp_cfg;
                                    end
                                    `IAPG_O_TP_PID: begin
                                        s_next.rhold = s_reg.tp_pid;
                                    end
                                    `IAPG_O_LEN_HI: begin
                                        s_next.rhold = s_reg.len_hi;
                                    end
                                    `IAPG_O_LEN_LO: begin
                                        s_next.rhold = s_reg.len_lo;
                                    end
                                    default: begin
                                        s_next.from_mem = map_cur[9];
                                    end
                                endcase
                            end else begin
                                s_next.from_mem = map_cur[9];
                            end
                            if (s_reg.ctl[`IAPG_CTL_AINC]) begin
                                s_next.off = next_off(s_reg.off);
                            end
                        end
                        `IAPG_A_P1_ALIAS: begin
                            // Bit 0 always reads zero
                            s_next.rhold = {s_reg.alias_id, 1'b0};
                        end
                        default: begin
                            // Reserved and unmapped read zero
                        end
                    endcase
                end
            end
            IAPG_READ: begin
                // Memory data has arrived; present it with the ack
                s_next.rdata = s_reg.from_mem ? mem_rdata
                                              : s_reg.rhold;
                s_next.ack   = 1'b1;
                s_next.st    = IAPG_IDLE;
            end
            IAPG_WALL: begin
                // Second copy of a broadcast write, channel 1
                mem_we    = 1'b1;
                mem_waddr = {1'b0, 3'(`IAPG_PG_CH1),
                             s_reg.woff[4:0]};
                mem_wdata = s_reg.whold;
                s_next.ack = 1'b1;
                s_next.st  = IAPG_IDLE;
            end
            default: begin
                // Unused code: recover to idle
                s_next.st = IAPG_IDLE;
            end
        endcase
    end

    // ==============================================================
    // State register
    // ==============================================================
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.st       <= IAPG_IDLE;
            s_reg.ctl      <= `IAPG_RST_ZERO;
            s_reg.off      <= `IAPG_RST_ZERO;
            s_reg.alias_id <= 7'h00;
            s_reg.tp_ctl   <= `IAPG_RST_ZERO;
            s_reg.tp_cfg   <= `IAPG_RST_CFG;
            s_reg.tp_pid   <= `IAPG_RST_PID;
            s_reg.len_hi   <= `IAPG_RST_LEN_HI;
            s_reg.len_lo   <= `IAPG_RST_LEN_LO;
            s_reg.rhold    <= `IAPG_RST_ZERO;
            s_reg.from_mem <= 1'b0;
            s_reg.rdata    <= `IAPG_RST_ZERO;
            s_reg.ack      <= 1'b0;
            s_reg.whold    <= `IAPG_RST_ZERO;
            s_reg.woff     <= `IAPG_RST_ZERO;
            s_reg.p1_match <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==============================================================
    // Outputs
    // ==============================================================

    // Bus answer
    assign reg_rdata = s_reg.rdata;
    assign reg_ack   = s_reg.ack;
    // Requests are ignored while a read or broadcast is in flight
    assign reg_busy  = (s_reg.st != IAPG_IDLE);

    // Alias decoder result, one cycle behind the address
    assign port1_match = s_reg.p1_match;

    // Pattern generator configuration fields
    assign testpattern_on     = s_reg.tp_ctl[`IAPG_TP_ON];
    assign fixed_color_select = s_reg.tp_cfg[`IAPG_FIX_BIT];
    assign color_bar_count    =
        s_reg.tp_cfg[`IAPG_BARS_HI:`IAPG_BARS_LO];
    assign bars_per_line      = bars_of(color_bar_count);
    assign block_size         = s_reg.tp_cfg[`IAPG_BLK_HI:0];
    assign packet_virtual_channel =
        s_reg.tp_pid[`IAPG_VC_HI:`IAPG_VC_LO];
    assign packet_data_type   = s_reg.tp_pid[`IAPG_DT_HI:0];
    assign active_line_bytes  = {s_reg.len_hi, s_reg.len_lo};
endmodule

// >>> testbench/iapg_regbank_monitor.sv
`timescale 1ns/1ns
// ==================================================================
// Port checker for the register bank
module iapg_regbank_monitor (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Register access
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_ack,
    input wire logic        reg_busy,
    // Decoder
    input wire logic [6:0]  i2c_target_addr,
    input wire logic        port1_match,
    // Generator settings
    input wire logic        testpattern_on,
    input wire logic        fixed_color_select,
    input wire logic [1:0]  color_bar_count,
    input wire logic [3:0]  bars_per_line,
    input wire logic [3:0]  block_size,
    input wire logic [1:0]  packet_virtual_channel,
    input wire logic [5:0]  packet_data_type,
    input wire logic [15:0] active_line_bytes
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_write_ack_next: assert property (reg_wr && !reg_busy &&
        reg_addr != 8'hb2 |=> reg_ack && !reg_busy)
        else $error("write not answered next cycle");
    a_read_busy_ack: assert property (reg_rd && !reg_wr &&
        !reg_busy |=> reg_busy ##1 (reg_ack && !reg_busy))
        else $error("read not answered two cycles later");
    a_busy_one_cycle: assert property ($rose(reg_busy)
        |=> !reg_busy && reg_ack)
        else $error("busy held too long or no answer");
    a_ack_has_cause: assert property (reg_ack |->
        $past(reg_busy) || $past(reg_wr && !reg_busy))
        else $error("answer without request");
    a_alias_zero_off: assert property (i2c_target_addr == 7'h00
        |=> !port1_match)
        else $error("decoder matched address zero");
    a_bar_decode: assert property (
        bars_per_line == (color_bar_count == 2'h3 ? 4'h8 :
        color_bar_count == 2'h2 ? 4'h4 :
        color_bar_count == 2'h1 ? 4'h2 : 4'h1))
        else $error("bar count decode wrong");
    // Settings may only move shortly after a write
    a_cfg_quiet: assert property ((!reg_wr)[*3] |=>
        $stable({testpattern_on, fixed_color_select, color_bar_count,
        block_size, packet_virtual_channel, packet_data_type,
        active_line_bytes}))
        else $error("settings changed without a write");
    a_reset_mode: assert property ($rose(rst_n) |->
        !testpattern_on && !fixed_color_select && color_bar_count == 2'h3)
        else $error("mode fields not at reset value");
    a_reset_format: assert property ($rose(rst_n) |->
        block_size == 4'h3 && packet_virtual_channel == 2'h0 &&
        packet_data_type == 6'h24)
        else $error("format fields not at reset value");
    a_reset_length: assert property ($rose(rst_n) |->
        active_line_bytes == 16'h0780)
        else $error("line length not at reset value");

    // Main scenarios reached
    c_write: cover property (reg_wr && !reg_busy ##1 reg_ack);
    c_read: cover property (reg_rd && !reg_busy ##2 reg_ack);
    c_match: cover property (port1_match);
endmodule

bind iapg_regbank iapg_regbank_monitor u_mon (.clk_sys, .rst_n, .reg_addr,
    .reg_wr, .reg_rd, .reg_ack, .reg_busy, .i2c_target_addr, .port1_match,
    .testpattern_on, .fixed_color_select, .color_bar_count, .bars_per_line,
    .block_size, .packet_virtual_channel, .packet_data_type,
    .active_line_bytes);

// >>> testbench/iapg_regbank_tb.sv
`timescale 1ns/1ns
// ==================================================================
// Self-checking bench for the register bank
module iapg_regbank_tb;
    logic        clk_sys, rst_n, reg_wr, reg_rd, reg_ack, reg_busy;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, q, v;
    logic [6:0]  i2c_target_addr, a;
    logic        port1_match, testpattern_on, fixed_color_select;
    logic [1:0]  color_bar_count, packet_virtual_channel;
    logic [3:0]  bars_per_line, block_size;
    logic [5:0]  packet_data_type;
    logic [15:0] active_line_bytes;
    logic [7:0]  d [5];
    int          mismatches, samples_checked, cycles;
    // Page codes and their last offsets
    logic [7:0]  pg [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
    logic [7:0]  lst [6] = '{8'h14, 8'h14, 8'h14, 8'h14, 8'h04, 8'h1d};
    logic [7:0]  rst_v [6] = '{8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80};

    iapg_regbank u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_busy(reg_busy), .i2c_target_addr(i2c_target_addr),
        .port1_match(port1_match), .testpattern_on(testpattern_on),
        .fixed_color_select(fixed_color_select),
        .color_bar_count(color_bar_count), .bars_per_line(bars_per_line),
        .block_size(block_size),
        .packet_virtual_channel(packet_virtual_channel),
        .packet_data_type(packet_data_type),
        .active_line_bytes(active_line_bytes));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Hang guard: the whole run needs far fewer cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bars per line as the bar count encoding defines them
    function automatic logic [3:0] exp_bars(input logic [1:0] code);
        return (code == 2'h3) ? 4'h8 : (code == 2'h2) ? 4'h4 :
               (code == 2'h1) ? 4'h2 : 4'h1;
    endfunction

    // One byte access; the request holds until the taking edge
    task automatic acc(input logic w, input logic [7:0] ad, dat);
        int n;
        n = 0;
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= ad;
        reg_wdata <= dat;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        // Answer comes in one or two cycles, bounded wait
        while (reg_ack !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        chk(reg_ack, 1'b1);
        q = reg_rdata;
    endtask

    task automatic wr(input logic [7:0] ad, dat);
        acc(1'b1, ad, dat);
    endtask

    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, rst_n} = '0;
        i2c_target_addr = 7'h00;
        void'($urandom(5714));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset contents of page 0 by auto-increment reads
        wr(8'hb0, 8'h02);
        wr(8'hb1, 8'h00);
        foreach (rst_v[i]) begin
            acc(1'b0, 8'hb2, 8'h00);
            chk(q, rst_v[i]);
        end
        chk(bars_per_line, exp_bars(2'h3));
        chk(active_line_bytes, 16'h0780);
        // Reserved and unmapped places ignore writes and read zero
        wr(8'hfa, 8'hff);
        foreach (lst[i]) begin
            acc(1'b0, i < 3 ? 8'hf9 + 8'(i) : 8'h10, 8'h00);
            chk(q, 8'h00);
        end
        acc(1'b0, 8'hb1, 8'h00);
        chk(q, 8'h06);
        // Random settings through an auto-increment burst
        for (int k = 0; k < 4; k++) begin
            foreach (d[i]) d[i] = 8'($urandom);
            if (k == 0) d[1] = 8'h8f;
            wr(8'hb1, 8'h01);
            foreach (d[i]) wr(8'hb2, d[i]);
            chk(testpattern_on, d[0][0]);
            chk(fixed_color_select, d[1][7]);
            chk(bars_per_line, exp_bars(d[1][5:4]));
            chk(color_bar_count, d[1][5:4]);
            chk(block_size, d[1][3:0]);
            chk(packet_virtual_channel, d[2][7:6]);
            chk(packet_data_type, d[2][5:0]);
            chk(active_line_bytes, {d[3], d[4]});
            wr(8'hb1, 8'h01);
            foreach (d[i]) begin
                acc(1'b0, 8'hb2, 8'h00);
                chk(q, d[i]);
            end
        end
        // Offset wraps after the top offset
        wr(8'hb1, 8'hff);
        wr(8'hb2, 8'h5a);
        acc(1'b0, 8'hb1, 8'h00);
        chk(q, 8'h00);
        // Timing window, auto-increment off keeps the offset
        v = 8'($urandom);
        wr(8'hb0, 8'h00);
        wr(8'hb1, 8'h48);
        wr(8'hb2, v);
        acc(1'b0, 8'hb2, 8'h00);
        acc(1'b0, 8'hb2, 8'h00);
        chk(q, v);
        acc(1'b0, 8'hb1, 8'h00);
        chk(q, 8'h48);
        // Every page code 1 to 7 except 6 at its last offset
        foreach (pg[i]) begin
            v = 8'($urandom);
            wr(8'hb0, pg[i]);
            wr(8'hb1, lst[i]);
            wr(8'hb2, v);
            acc(1'b0, 8'hb2, 8'h00);
            chk(q, v);
        end
        // Broadcast reaches both channel pages
        v = 8'($urandom);
        wr(8'hb0, 8'h18);
        wr(8'hb1, 8'h14);
        wr(8'hb2, v);
        for (int i = 0; i < 2; i++) begin
            wr(8'hb0, pg[i]);
            acc(1'b0, 8'hb2, 8'h00);
            chk(q, v);
        end
        // Page code above seven is unmapped
        wr(8'hb0, 8'h20);
        acc(1'b0, 8'hb2, 8'h00);
        chk(q, 8'h00);
        // Alias decoder: stored, bit zero reads zero, zero disables
        a = 7'($urandom_range(127, 1));
        wr(8'hf9, {a, 1'b1});
        acc(1'b0, 8'hf9, 8'h00);
        chk(q, {a, 1'b0});
        @(posedge clk_sys) i2c_target_addr <= a;
        @(posedge clk_sys) @(negedge clk_sys);
        chk(port1_match, 1'b1);
        @(posedge clk_sys) i2c_target_addr <= a ^ 7'h01;
        @(posedge clk_sys) @(negedge clk_sys);
        chk(port1_match, 1'b0);
        wr(8'hf9, 8'h00);
        @(posedge clk_sys) i2c_target_addr <= 7'h00;
        @(posedge clk_sys) @(negedge clk_sys);
        chk(port1_match, 1'b0);
        conclude();
    end
endmodule
